/* File: shared/dsc_defs.vh */
// Constants for the sequencer clock and clear block
// Function
// [R1] External clock divided by four advances sequencer
// [R2] External clock when word bit or pin high
// [R3] Select pin high stops internal oscillator
// [R4] No progress while external clock stands still
// [R5] Power-up clear writes 4F3 to every channel
// [R6] Reset pin low runs same clear sequence
// [R7] Clear sequence always uses internal clock
// [R8] Clear uninterruptible; serial input ignored meanwhile
// [R9] Word bit zero internal, one external
// [R10] Host repeats word bit in every word
// [R11] Disagreement: the input at one wins
// [R12] Four external cycles per channel, 128 total
// [R13] After clear, resume with current selection
`ifndef DSC_DEFS_VH
`define DSC_DEFS_VH
`define DSC_CLEAR_CODE 12'h4F3
`define DSC_CHANNELS 32
`define DSC_EXT_DIV 4
`define DSC_CLEAR_TIME_NS 320000
`define DSC_CLK_PERIOD_NS 8
`define DSC_CHAN_TIME_NS (`DSC_CLEAR_TIME_NS / `DSC_CHANNELS)
`define DSC_CHAN_CYCLES ((`DSC_CHAN_TIME_NS + `DSC_CLK_PERIOD_NS - 1) / `DSC_CLK_PERIOD_NS)
`endif

/* File: rtl/dsc_edge_div.v */
// Sync, edge detect and divide-by-N of the external sequencer clock
`timescale 1ns/1ps
module dsc_edge_div #(
    parameter DIV = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire enable,
    // Pin
    input wire extClk,
    // Step
    output reg stepPulse
);
    reg sync1_ff;
    reg sync2_ff;
    reg last_ff;
    reg [7:0] cnt_ff;
    wire rise;
    wire [31:0] divLast;
    assign rise = sync2_ff & ~last_ff;
    // Terminal count kept at full width, then cut on purpose
    assign divLast = DIV - 1;
    always @(posedge clk)
    begin
        if (rst)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            last_ff <= 1'b0;
            cnt_ff <= 8'h00;
            stepPulse <= 1'b0;
        end
        else
        begin
            sync1_ff <= extClk;
            sync2_ff <= sync1_ff;
            last_ff <= sync2_ff;
            stepPulse <= 1'b0;
            if (!enable)
                cnt_ff <= 8'h00;
            else if (rise) // No edge, no progress [R4]
            begin
                if (cnt_ff == divLast[7:0]) // Quarter rate step [R1]
                begin
                    cnt_ff <= 8'h00;
                    stepPulse <= 1'b1;
                end
                else
                    cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end
endmodule // dsc_edge_div

/* File: rtl/dsc_seq_ctrl.v */
// Sequencer clock selection and clear sequence control
`timescale 1ns/1ps
`include "dsc_defs.vh"
module dsc_seq_ctrl #(
    parameter CHAN_CYCLES = `DSC_CHAN_CYCLES,
    parameter CHANNELS = `DSC_CHANNELS
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Pins
    input wire ext_seq_clock_in,
    input wire clock_source_pin,
    input wire resetPin_n,
    // Serial word
    input wire wordValid,
    input wire word_clock_select_bit,
    // Channel write
    output reg chanWrite,
    output reg [4:0] chanAddr,
    output reg [11:0] chanCode,
    output reg clearCode,
    // Status
    output reg clearBusy,
    output reg extSelected,
    output reg oscEnable,
    output reg wordAccept
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg pinSel1_ff;
    reg pinSel2_ff;
    reg rst1_ff;
    reg rst2_ff;
    reg rstLast_ff;
    reg wordBit_ff;
    reg [15:0] div_ff;
    reg [4:0] chan_ff;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    localparam IDLE = 2'b00;
    localparam CLEAR = 2'b01;
    wire extStep;
    wire intStep;
    wire useExt;
    wire step;
    wire startClear;
    wire chanStep;
    always @(posedge clk)
    begin
        if (rst)
        begin
            pinSel1_ff <= 1'b0;
            pinSel2_ff <= 1'b0;
            rst1_ff <= 1'b1;
            rst2_ff <= 1'b1;
            rstLast_ff <= 1'b1;
        end
        else
        begin
            pinSel1_ff <= clock_source_pin;
            pinSel2_ff <= pinSel1_ff;
            rst1_ff <= resetPin_n;
            rst2_ff <= rst1_ff;
            rstLast_ff <= rst2_ff;
        end
    end
    // ****************************************
    // Clock selection
    // ****************************************
    // Either input at one picks the external clock [R2] [R11]
    assign useExt = (wordBit_ff | pinSel2_ff) && state_ff == IDLE; // [R7] [R13]
    // Internal oscillator ticks once per channel slot; stopped by pin unless clearing
    assign intStep = (div_ff == CHAN_CYCLES - 1) && oscEnable;
    assign startClear = rstLast_ff & ~rst2_ff; // [R6]
    dsc_edge_div #(
        .DIV(`DSC_EXT_DIV)
    ) uDiv (
        .clk(clk),
        .rst(rst),
        .enable(useExt),
        .extClk(ext_seq_clock_in),
        .stepPulse(extStep)
    );
    // Four external edges per channel, 128 over the loop [R12]
    assign step = useExt ? extStep : intStep;
    // ****************************************
    // Step decode
    // ****************************************
    // Clearing follows the internal tick only, whatever the selection [R7]
    function stepFor;
        input [1:0] st;
        input intTick;
        input anyTick;
        begin
            if (st == CLEAR)
                stepFor = intTick;
            else
                stepFor = anyTick;
        end
    endfunction
    assign chanStep = stepFor(state_ff, intStep, step);
    // ****************************************
    // Clear state machine
    // ****************************************
    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            IDLE:
            begin
                if (startClear)
                    nxt_state = CLEAR;
            end
            CLEAR:
            begin
                // Runs to the end; pin edges meanwhile are dropped [R8]
                if (intStep && chan_ff == CHANNELS - 1)
                    nxt_state = IDLE;
            end
            default:
            begin
                nxt_state = IDLE;
            end
        endcase
    end
    // ****************************************
    // State and internal oscillator
    // ****************************************
    always @(posedge clk)
    begin
        if (rst)
        begin
            state_ff <= CLEAR; // Power-up clear [R5]
            div_ff <= 16'h0000;
            oscEnable <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            // Oscillator off with pin high, forced on while clearing [R3] [R7]
            oscEnable <= ~pinSel2_ff | (nxt_state == CLEAR);
            if (!oscEnable || intStep)
                div_ff <= 16'h0000;
            else
                div_ff <= div_ff + 16'h0001;
        end
    end
    // ****************************************
    // Channel pointer
    // ****************************************
    always @(posedge clk)
    begin
        if (rst)
        begin
            chan_ff <= 5'h00;
        end
        else
        begin
            // Clear always begins at channel zero
            if (state_ff == IDLE && startClear)
                chan_ff <= 5'h00;
            else if (chanStep)
                chan_ff <= chan_ff + 5'h01;
        end
    end
    // ****************************************
    // Serial word control bit
    // ****************************************
    always @(posedge clk)
    begin
        if (rst)
        begin
            wordBit_ff <= 1'b0;
            wordAccept <= 1'b0;
        end
        else
        begin
            // Word bit latched per word; host must repeat it [R9] [R10]
            if (wordValid && state_ff == IDLE && !startClear) // Ignored during clear [R8]
                wordBit_ff <= word_clock_select_bit;
            wordAccept <= wordValid && state_ff == IDLE && !startClear;
        end
    end
    // ****************************************
    // Outputs
    // ****************************************
    always @(posedge clk)
    begin
        if (rst)
        begin
            chanWrite <= 1'b0;
            chanAddr <= 5'h00;
            chanCode <= 12'h000;
            clearCode <= 1'b0;
            clearBusy <= 1'b1;
            extSelected <= 1'b0;
        end
        else
        begin
            chanWrite <= chanStep;
            chanAddr <= chan_ff;
            chanCode <= `DSC_CLEAR_CODE; // [R5]
            clearCode <= (state_ff == CLEAR);
            clearBusy <= (nxt_state == CLEAR);
            // Dropped in the very cycle a clear begins, not one later [R7]
            extSelected <= useExt && (nxt_state == IDLE);
        end
    end
endmodule // dsc_seq_ctrl

/* File: bench/dsc_chk.sv */
// Assertion checker for the sequencer clock and clear block
`timescale 1ns/1ps
module dsc_chk #(parameter CHAN_CYCLES = 4, parameter CHANNELS = 32) (
    // In
    input wire clk, rst, ext_seq_clock_in, clock_source_pin, resetPin_n, wordValid, word_clock_select_bit,
    // Out
    input wire chanWrite, clearCode, clearBusy, extSelected, oscEnable, wordAccept,
    input wire [4:0] chanAddr,
    input wire [11:0] chanCode
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_clear_code: assert property (chanWrite && clearCode |-> chanCode == 12'h4F3) else $error("clear code");
    a_clear_start: assert property ($fell(rst) |-> clearBusy) else $error("no clear");
    a_clear_clock: assert property (clearBusy |-> !extSelected && oscEnable) else $error("clear clock");
    a_word_drop: assert property (wordValid && clearBusy |=> !wordAccept) else $error("word taken");
    a_word_ack: assert property (wordValid && !clearBusy |=> wordAccept) else $error("word lost");
    // Pin passes two sync stages first
    a_pin_ext: assert property (clock_source_pin [*4] ##0 !clearBusy [*2] |-> extSelected)
        else $error("pin ignored");
    a_pin_osc: assert property (clock_source_pin [*4] ##0 !clearBusy [*2] |-> !oscEnable)
        else $error("osc runs");
    a_ext_halt: assert property ((extSelected && $stable(ext_seq_clock_in)) [*6] |-> !chanWrite)
        else $error("step on halt");
endmodule // dsc_chk

bind dsc_seq_ctrl dsc_chk #(.CHAN_CYCLES(CHAN_CYCLES), .CHANNELS(CHANNELS)) chk_u (.clk, .rst, .ext_seq_clock_in,
    .clock_source_pin, .resetPin_n, .wordValid, .word_clock_select_bit, .chanWrite, .clearCode, .clearBusy,
    .extSelected, .oscEnable, .wordAccept, .chanAddr, .chanCode);

/* File: bench/dsc_host.sv */
// Host model making the external sequencer clock
`timescale 1ns/1ps
module dsc_host (
    // Control
    input wire run,
    // Pin
    output reg extClk
);
    initial extClk = 1'b0;
    // Own phase; stands low when stopped
    always #20 extClk <= run ? ~extClk : 1'b0;
endmodule // dsc_host

/* File: bench/dsc_seq_ctrl_tb.sv */
// Testbench for the sequencer clock and clear block
`timescale 1ns/1ps
module dsc_seq_ctrl_tb;
    reg clk = 0, rst = 1, pin = 0, rstN = 1, wv = 0, wb = 0, run = 0;
    wire ext, cw, cc, cb, es, oe, wa;
    wire [4:0] ca;
    wire [11:0] cd;
    integer err_total = 0, num_checks = 0, cnt = 0, i, n;
    always #4 clk = ~clk;
    always @(negedge clk) if (cw) cnt = cnt + 1;
    dsc_host host_u (.run(run), .extClk(ext));
    dsc_seq_ctrl #(.CHAN_CYCLES(4)) dut_u (.clk(clk), .rst(rst), .ext_seq_clock_in(ext), .clock_source_pin(pin),
        .resetPin_n(rstN), .wordValid(wv), .word_clock_select_bit(wb), .chanWrite(cw), .chanAddr(ca), .chanCode(cd),
        .clearCode(cc), .clearBusy(cb), .extSelected(es), .oscEnable(oe), .wordAccept(wa));
    task check(input [31:0] seen, input [31:0] want);
    begin
        num_checks = num_checks + 1;
        if (seen !== want)
        begin
            err_total = err_total + 1;
            $display("BAD %0t seen %0h want %0h", $time, seen, want);
        end
    end
    endtask
    task give_verdict;
    begin
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task word(input b, input acc);
    begin
        @(posedge clk) {wv, wb} <= {1'b1, b};
        @(posedge clk) wv <= 0;
        @(negedge clk) check(wa, acc);
    end
    endtask
    // Counts clear writes in order; bounded wait
    task clear_run;
    begin
        n = 0;
        for (i = 0; i < 300 && cb === 1'b1; i = i + 1)
        begin
            @(negedge clk);
            if (cw === 1'b1 && cc === 1'b1)
            begin
                check(ca, n);
                check(cd, 12'h4F3);
                n = n + 1;
            end
        end
        check(n, 32);
        if (cb !== 1'b0)
        begin
            check(cb, 0);
            give_verdict;
        end
    end
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 0;
        word(1, 0);
        clear_run;
        check(es, 0);
        word(1, 1);
        @(negedge clk);
        check(es, 1);
        @(posedge clk) run <= 1;
        cnt = 0;
        repeat (128) @(posedge ext);
        @(posedge clk) run <= 0;
        repeat (8) @(negedge clk);
        check(cnt, 32);
        cnt = 0;
        repeat (60) @(negedge clk);
        check(cnt, 0);
        word(0, 1);
        @(negedge clk);
        check(es, 0);
        @(posedge clk) pin <= 1;
        repeat (6) @(negedge clk);
        check({es, oe}, 2'b10);
        @(posedge clk) rstN <= 0;
        repeat (4) @(negedge clk);
        check({cb, es}, 2'b10);
        @(posedge clk) rstN <= 1;
        clear_run;
        repeat (2) @(negedge clk);
        check(es, 1);
        give_verdict;
    end
    initial
    begin
        #100000 check(0, 1);
        give_verdict;
    end
endmodule // dsc_seq_ctrl_tb
